// [shared/esp_cfg.svh]
// constants for the external bus strobe pin mux: offsets, fields, resets
// assumes a 32-bit plain register port with byte addresses
`ifndef ESP_CFG_SVH
`define ESP_CFG_SVH

// register byte offsets
`define ESP_CTRL_OFS 8'h00
`define ESP_STAT_OFS 8'h04

// control register field positions
`define ESP_CTRL_EXT_BIT 0
`define ESP_CTRL_NONMUX_BIT 1
`define ESP_CTRL_BUS16_BIT 2
`define ESP_CTRL_WSTRB_BIT 3

// control register reset value: single chip mode, all pins general purpose
`define ESP_CTRL_RESET 4'h0

// shared pin indices
`define ESP_PIN_P5L0 0
`define ESP_PIN_P5L1 1
`define ESP_PIN_P5L2 2
`define ESP_PIN_P5L3 3
`define ESP_PIN_A14 4
`define ESP_PIN_A15 5

// number of shared pins
`define ESP_NUM_PINS 6

`endif

// [shared/esp_pkg.sv]
// types for the external bus strobe pin mux
// assumes esp_cfg.svh is on the include path
`include "esp_cfg.svh"
`default_nettype none

package esp_pkg;

	// registered control, read data and pad drive of the mux top
	typedef struct packed {
		logic ext_bus_mode;
		logic nonmux_addr;
		logic bus_width_16;
		logic write_strobe_pin_enable;
		logic [31:0] rdata;
		logic [`ESP_NUM_PINS-1:0] pad_out;
		logic [`ESP_NUM_PINS-1:0] pad_oe;
	} esp_state_s;

endpackage : esp_pkg

`default_nettype wire

// [rtl/esp_pin_sync.sv]
// three-stage input synchroniser with agreement filter for pad levels
// assumes asynchronous pad inputs and a synchronised active-low reset
`timescale 1ns/10ps
`default_nettype none

module esp_pin_sync #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// asynchronous levels in, filtered levels out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} esp_sync_s;

	esp_sync_s st;
	esp_sync_s next_st;

	// s1 feeds only s2; a level counts once s2 and s3 agree, so a
	// pad caught mid-change never reaches q
	always_comb begin
		next_st = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.q = (st.s3 & ~(st.s2 ^ st.s3)) | (st.q & (st.s2 ^ st.s3));
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.q;

endmodule : esp_pin_sync

`default_nettype wire

// [rtl/esp_strobe_pin_mux.sv]
// pin function select for port 5 lines 0..3 and upper address lines 14/15
// assumes bus strobes and gpio signals come from logic on sys_clk_i
//
// Overview of operation
// - external bus mode with non-multiplexed addressing: upper shared pins carry address lines 14 and 15
// - external bus mode: port 5 line 0 carries the address latch strobe
// - external bus mode: port 5 line 1 carries the active-low read strobe
// - external bus with write strobe enable set: line 2 is low byte strobe
// - write strobe enable clear: line 2 stays general purpose
// - line 3 is high byte strobe only with ext bus, 16-bit, enable set
//
// Implementation choices: the plain strobed port and the address map.
`include "esp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module esp_strobe_pin_mux (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// external bus controller strobes and address
	input wire logic addr_latch_strobe_i,
	input wire logic read_strobe_n_i,
	input wire logic low_byte_write_strobe_n_i,
	input wire logic high_byte_write_strobe_n_i,
	input wire logic addr_line_14_i,
	input wire logic addr_line_15_i,
	// general purpose port side
	input wire logic [5:0] gpio_out_i,
	input wire logic [5:0] gpio_oe_i,
	output logic [5:0] gpio_in_o,
	// pads: index 0..3 port5_line0..3, 4 and 5 address lines 14 and 15
	input wire logic [5:0] pad_in_i,
	output logic [5:0] pad_out_o,
	output logic [5:0] pad_oe_o
);

	logic [1:0] rst_sync;
	logic rst_n;
	esp_pkg::esp_state_s st;
	esp_pkg::esp_state_s next_st;
	logic [5:0] alt_sel;
	logic [5:0] alt_val;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// pad levels cross in through the agreement filter
	esp_pin_sync #(
		.WIDTH(6)
	) u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.d_i(pad_in_i),
		.q_o(gpio_in_o)
	);

	// alternate function select per pin, from registered control only
	always_comb begin
		alt_sel = 6'h00;
		alt_sel[`ESP_PIN_P5L0] = st.ext_bus_mode;
		alt_sel[`ESP_PIN_P5L1] = st.ext_bus_mode;
		alt_sel[`ESP_PIN_P5L2] = st.ext_bus_mode & st.write_strobe_pin_enable;
		alt_sel[`ESP_PIN_P5L3] = st.ext_bus_mode & st.bus_width_16 &
			st.write_strobe_pin_enable;
		alt_sel[`ESP_PIN_A14] = st.ext_bus_mode & st.nonmux_addr;
		alt_sel[`ESP_PIN_A15] = st.ext_bus_mode & st.nonmux_addr;
	end

	// alternate values in pad order
	assign alt_val = {addr_line_15_i, addr_line_14_i,
		high_byte_write_strobe_n_i, low_byte_write_strobe_n_i,
		read_strobe_n_i, addr_latch_strobe_i};

	// next state: register writes, read data, registered pad drive
	always_comb begin
		next_st = st;
		if (reg_wr_i && reg_addr_i == `ESP_CTRL_OFS) begin
			next_st.ext_bus_mode = reg_wdata_i[`ESP_CTRL_EXT_BIT];
			next_st.nonmux_addr = reg_wdata_i[`ESP_CTRL_NONMUX_BIT];
			next_st.bus_width_16 = reg_wdata_i[`ESP_CTRL_BUS16_BIT];
			next_st.write_strobe_pin_enable =
				reg_wdata_i[`ESP_CTRL_WSTRB_BIT];
		end
		// read data stands one cycle only; unmapped reads give zero
		next_st.rdata = 32'h0000_0000;
		if (reg_rd_i) begin
			if (reg_addr_i == `ESP_CTRL_OFS) begin
				next_st.rdata[`ESP_CTRL_EXT_BIT] = st.ext_bus_mode;
				next_st.rdata[`ESP_CTRL_NONMUX_BIT] = st.nonmux_addr;
				next_st.rdata[`ESP_CTRL_BUS16_BIT] = st.bus_width_16;
				next_st.rdata[`ESP_CTRL_WSTRB_BIT] =
					st.write_strobe_pin_enable;
			end else if (reg_addr_i == `ESP_STAT_OFS) begin
				next_st.rdata[5:0] = alt_sel;
			end
		end
		// a pin not taken by the bus stays under port control
		next_st.pad_out = (alt_sel & alt_val) | (~alt_sel & gpio_out_i);
		next_st.pad_oe = alt_sel | (~alt_sel & gpio_oe_i);
	end

	// single state register; pads come up undriven after reset
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			// control fields come from the reset word, cut to one bit each
			st.ext_bus_mode <= 1'(`ESP_CTRL_RESET >> `ESP_CTRL_EXT_BIT);
			st.nonmux_addr <= 1'(`ESP_CTRL_RESET >> `ESP_CTRL_NONMUX_BIT);
			st.bus_width_16 <= 1'(`ESP_CTRL_RESET >> `ESP_CTRL_BUS16_BIT);
			st.write_strobe_pin_enable <=
				1'(`ESP_CTRL_RESET >> `ESP_CTRL_WSTRB_BIT);
			st.rdata <= 32'h0000_0000;
			st.pad_out <= 6'h00;
			st.pad_oe <= 6'h00;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_o = st.rdata;
	assign pad_out_o = st.pad_out;
	assign pad_oe_o = st.pad_oe;

	// checks on pad routing and the register port, one cycle after the select or access is seen
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	a_addr_hi_route: assert property (
		st.ext_bus_mode && st.nonmux_addr |=> pad_oe_o[5:4] == 2'h3 &&
			pad_out_o[5:4] == $past({addr_line_15_i, addr_line_14_i}))
		else $error("upper address pins not driven from address lines");

	a_addr_hi_gpio: assert property (
		!(st.ext_bus_mode && st.nonmux_addr) |=>
			pad_oe_o[5:4] == $past(gpio_oe_i[5:4]) &&
			pad_out_o[5:4] == $past(gpio_out_i[5:4]))
		else $error("upper address pins left port control wrongly");

	a_ale_route: assert property (
		st.ext_bus_mode |=> pad_oe_o[0] && pad_out_o[0] ==
			$past(addr_latch_strobe_i))
		else $error("latch strobe not on port 5 line 0");

	a_read_route: assert property (
		st.ext_bus_mode ##1 !$past(read_strobe_n_i) |-> pad_oe_o[1] &&
			!pad_out_o[1])
		else $error("read strobe not on port 5 line 1");

	a_low_strobe_route: assert property (
		st.ext_bus_mode && st.write_strobe_pin_enable |=> pad_oe_o[2] &&
			pad_out_o[2] == $past(low_byte_write_strobe_n_i))
		else $error("low byte write strobe not on port 5 line 2");

	a_low_strobe_gpio: assert property (
		!st.write_strobe_pin_enable |=> pad_oe_o[2] == $past(gpio_oe_i[2])
			&& pad_out_o[2] == $past(gpio_out_i[2]))
		else $error("port 5 line 2 taken while strobe enable clear");

	a_high_strobe_route: assert property (
		st.ext_bus_mode && st.bus_width_16 && st.write_strobe_pin_enable
			|=> pad_oe_o[3] &&
			pad_out_o[3] == $past(high_byte_write_strobe_n_i))
		else $error("high byte write strobe not on port 5 line 3");

	// 8-bit bus or strobe enable clear: line 3 must stay with the port
	a_high_strobe_gpio: assert property (
		!(st.ext_bus_mode && st.bus_width_16 &&
			st.write_strobe_pin_enable) |=>
			pad_oe_o[3] == $past(gpio_oe_i[3]) &&
			pad_out_o[3] == $past(gpio_out_i[3]))
		else $error("port 5 line 3 taken without 16-bit strobe setup");

	a_single_chip: assert property (
		!st.ext_bus_mode |=> pad_oe_o == $past(gpio_oe_i) &&
			pad_out_o == $past(gpio_out_i))
		else $error("pin taken outside external bus mode");

	a_ctrl_write: assert property (
		reg_wr_i && reg_addr_i == `ESP_CTRL_OFS |=> st.ext_bus_mode ==
			$past(reg_wdata_i[`ESP_CTRL_EXT_BIT]) ##1 ($past(reg_rd_i) ||
			reg_rdata_o == 32'h0000_0000))
		else $error("control write lost or read data lingers");

	// status view must follow the select rules, not just echo alt_sel
	a_status_read: assert property (
		reg_rd_i && reg_addr_i == `ESP_STAT_OFS |=>
			reg_rdata_o[31:6] == 26'h0 &&
			reg_rdata_o[5:4] == {2{$past(st.ext_bus_mode &&
			st.nonmux_addr)}} &&
			reg_rdata_o[3] == $past(st.ext_bus_mode && st.bus_width_16 &&
			st.write_strobe_pin_enable) &&
			reg_rdata_o[2] == $past(st.ext_bus_mode &&
			st.write_strobe_pin_enable) &&
			reg_rdata_o[1:0] == {2{$past(st.ext_bus_mode)}})
		else $error("status read disagrees with pin selection");

	// software relies on idle read data being zero between reads
	a_read_idle_zero: assert property (
		!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("read data stands without a read strobe");

	a_unmapped_read: assert property (
		reg_rd_i && reg_addr_i != `ESP_CTRL_OFS &&
			reg_addr_i != `ESP_STAT_OFS |=> reg_rdata_o == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");

	c_full_16bit: cover property (st.ext_bus_mode && st.nonmux_addr &&
		st.bus_width_16 && st.write_strobe_pin_enable);
	c_8bit_strobe: cover property (st.ext_bus_mode &&
		st.write_strobe_pin_enable && !st.bus_width_16);
	c_status_read: cover property (reg_rd_i && reg_addr_i == `ESP_STAT_OFS
		##1 reg_rdata_o != 32'h0000_0000);
	c_mode_leave: cover property (st.ext_bus_mode ##1 !st.ext_bus_mode);
	c_read_routed: cover property (st.ext_bus_mode && !read_strobe_n_i
		##1 pad_oe_o[1]);

endmodule : esp_strobe_pin_mux

`default_nettype wire

// [test/esp_bus_model.sv]
// far side model: external memory or peripheral on the shared bus pins
// assumes pad drive and enable come from the mux, one level per pin
`timescale 1ns/10ps
`default_nettype none

module esp_bus_model (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// pad drive from the mux
	input wire logic [5:0] pad_out_i,
	input wire logic [5:0] pad_oe_i,
	// resolved wire level
	output logic [5:0] pad_level_o
);
	logic [5:0] float_q;

	// undriven pins toggle so a stale level never passes for a drive
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			float_q <= 6'h15;
		end else begin
			float_q <= ~float_q;
		end
	end

	// the mux wins wherever it drives, the memory side never fights it
	assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & float_q);
endmodule : esp_bus_model

`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the strobe pin mux, random with fixed seed
// assumes the far side model resolves the pad wires
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, r;
	logic [5:0] bus_sig, gpio_out, gpio_oe, gpio_in, pad_in, pad_out, pad_oe;
	logic [3:0] ctrl;
	logic [11:0] e;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 32'h7334;

	esp_strobe_pin_mux u_esp_strobe_pin_mux (.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .addr_latch_strobe_i(bus_sig[0]),
		.read_strobe_n_i(bus_sig[1]), .low_byte_write_strobe_n_i(bus_sig[2]),
		.high_byte_write_strobe_n_i(bus_sig[3]), .addr_line_14_i(bus_sig[4]),
		.addr_line_15_i(bus_sig[5]), .gpio_out_i(gpio_out),
		.gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_o(pad_oe));
	esp_bus_model u_esp_bus_model (.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
		.pad_level_o(pad_in));

	// 125 MHz system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	// pins that take their bus role for a given control value
	function automatic logic [5:0] alt_mask(input logic [3:0] c);
		return {{2{c[0] & c[1]}}, c[0] & c[2] & c[3], c[0] & c[3], {2{c[0]}}};
	endfunction : alt_mask

	// expected {oe, out}: bus role drives always, else port control
	function automatic logic [11:0] exp_pads(input logic [3:0] c);
		logic [5:0] m;
		m = alt_mask(c);
		return {m | gpio_oe, (m & bus_sig) | (~m & gpio_out)};
	endfunction : exp_pads

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// read data stands one cycle only, then returns to zero
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, want);
		@(posedge sys_clk_i);
		#1 chk(reg_rdata_o, 32'h0);
	endtask : rd

	task automatic conclude;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial begin
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		{bus_sig, gpio_out, gpio_oe} = '0;
		resetn_i = 1'b0;
		repeat (12) @(posedge sys_clk_i);
		#1 chk({pad_oe, reg_rdata_o[5:0]}, 12'h0);
		@(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rd(8'h00, 32'h0);
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		// every mode combination, random junk in the unused upper bits
		for (int k = 0; k < 16; k++) begin
			ctrl = k[3:0];
			r = $random(seed);
			wr(8'h00, {r[31:4], ctrl});
			rd(8'h00, {28'h0, ctrl});
			rd(8'h04, {26'h0, alt_mask(ctrl)});
			repeat (8) begin
				@(posedge sys_clk_i);
				r = $random(seed);
				bus_sig <= r[5:0];
				gpio_out <= r[13:8];
				gpio_oe <= r[21:16];
				@(posedge sys_clk_i);
				#1 chk({pad_oe, pad_out}, exp_pads(ctrl));
			end
			// hold inputs still; driven pads must come back on gpio_in
			e = exp_pads(ctrl);
			repeat (6) @(posedge sys_clk_i);
			#1 chk(gpio_in & e[11:6], e[5:0] & e[11:6]);
		end
		conclude();
	end
endmodule : testbench

`default_nettype wire
